// File: hdl/cmpc_defs.svh
// constants of the comparator control register bank
`ifndef CMPC_DEFS_SVH
`define CMPC_DEFS_SVH
`define CMPC_OFF_CTRL_A   32'h0000_0000
`define CMPC_OFF_CTRL_B   32'h0000_0004
`define CMPC_OFF_IRQ_STAT 32'h0000_0008
`define CMPC_OFF_IRQ_MASK 32'h0000_000c
`define CMPC_BIT_RESULT   7
`define CMPC_BIT_DRIVE_N  6
`define CMPC_BIT_POL      5
`define CMPC_BIT_SEL4     4
`define CMPC_BIT_ENABLE   3
`define CMPC_BIT_NEG      2
`define CMPC_BIT_SEL1     1
`define CMPC_BIT_WAKE_N   0
`define CMPC_CTRL_RESET   8'hff
`define CMPC_IRQ_RESET    2'h0
`define CMPC_WARM_CYCLES  3'h4
`define CMPC_RESP_OKAY    2'h0
`define CMPC_RESP_SLVERR  2'h2
`endif

// File: hdl/cmpc_pkg.sv
// types of the comparator control register bank
package cmpc_pkg;
    typedef struct packed {
        logic pos_pin;
        logic neg_pin;
    } cmpc_analog_type;
    typedef struct packed {
        logic result;
        logic pin_out;
        logic pin_oe_n;
        logic wake_en;
    } cmpc_side_type;
    typedef enum logic [1:0] {
        CMPC_RD_IDLE = 2'h1,
        CMPC_RD_RESP = 2'h2
    } cmpc_rd_state_type;
endpackage : cmpc_pkg

// File: hdl/cmpc_regs.sv
// comparator control register bank with axi4-lite slave
`timescale 1ns/1ps
`include "cmpc_defs.svh"
module cmpc_regs #(
    parameter bit TWO_CMP = 1'b1
) (
    input  wire logic                    aclk,
    input  wire logic                    aresetn,
    input  wire logic [31:0]             s_axi_awaddr,
    input  wire logic                    s_axi_awvalid,
    output logic                         s_axi_awready,
    input  wire logic [31:0]             s_axi_wdata,
    input  wire logic [3:0]              s_axi_wstrb,
    input  wire logic                    s_axi_wvalid,
    output logic                         s_axi_wready,
    output logic [1:0]                   s_axi_bresp,
    output logic                         s_axi_bvalid,
    input  wire logic                    s_axi_bready,
    input  wire logic [31:0]             s_axi_araddr,
    input  wire logic                    s_axi_arvalid,
    output logic                         s_axi_arready,
    output logic [31:0]                  s_axi_rdata,
    output logic [1:0]                   s_axi_rresp,
    output logic                         s_axi_rvalid,
    input  wire logic                    s_axi_rready,
    input  wire cmpc_pkg::cmpc_analog_type cmp_a_in,
    input  wire cmpc_pkg::cmpc_analog_type cmp_b_in,
    input  wire logic                    vref_a_gt,
    input  wire logic                    vref_b_gt,
    input  wire logic                    timer_clock_source_option,
    input  wire logic                    t0_pin_clk,
    output cmpc_pkg::cmpc_side_type      cmp_a_side,
    output cmpc_pkg::cmpc_side_type      cmp_b_side,
    output logic                         cmp_a_enable,
    output logic                         cmp_b_enable,
    output logic                         vref_enable,
    output logic                         timer_zero_clk,
    output logic                         timer_pin_override,
    output logic                         wake_req,
    output logic                         irq
);
    logic [7:0] ctrl_a_ff;
    logic [7:0] ctrl_b_ff;
    logic [1:0] irq_stat_ff;
    logic [1:0] irq_mask_ff;
    logic [2:0] sync_a_ff;
    logic [2:0] sync_b_ff;
    logic [2:0] sync_pa_ff;
    logic [2:0] sync_pb_ff;
    logic [2:0] sync_na_ff;
    logic [2:0] sync_nb_ff;
    logic [2:0] sync_t_ff;
    logic       raw_a_ff;
    logic       raw_b_ff;
    logic       pa_ff;
    logic       pb_ff;
    logic       na_ff;
    logic       nb_ff;
    logic       tpin_ff;
    logic       res_a_ff;
    logic       res_b_ff;
    logic       res_a_old_ff;
    logic       res_b_old_ff;
    logic       out_a_ff;
    logic       out_b_ff;
    logic       tclk_ff;
    logic       aw_got_ff;
    logic       w_got_ff;
    logic [31:0] aw_addr_ff;
    logic [7:0] wdata_ff;
    logic       wr_strb_ff;
    logic       bvalid_ff;
    logic [1:0] bresp_ff;
    logic [31:0] rdata_ff;
    logic [1:0] rresp_ff;
    cmpc_pkg::cmpc_rd_state_type rd_state_ff;
    logic       wr_go;
    logic [1:0] chg;
    logic       nxt_a;
    logic       nxt_b;
    logic       b_pos;
    logic       b_neg;
    logic [2:0] warm_ff;

    // three-stage filter: a change counts once stages two and three agree
    function automatic logic filt(input logic [2:0] s, input logic held);
        filt = (s[1] == s[2]) ? s[2] : held;
    endfunction : filt

    // polarity 1 passes result, 0 inverts
    function automatic logic pol(input logic raw, input logic p);
        pol = p ? raw : ~raw;
    endfunction : pol

    //--------------------------------------------------------------
    // input synchronisers
    //--------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync_a_ff  <= 3'h0;
            sync_b_ff  <= 3'h0;
            sync_pa_ff <= 3'h0;
            sync_pb_ff <= 3'h0;
            sync_na_ff <= 3'h0;
            sync_nb_ff <= 3'h0;
            sync_t_ff  <= 3'h0;
            raw_a_ff   <= 1'b0;
            raw_b_ff   <= 1'b0;
            pa_ff      <= 1'b0;
            pb_ff      <= 1'b0;
            na_ff      <= 1'b0;
            nb_ff      <= 1'b0;
            tpin_ff    <= 1'b0;
        end else begin
            sync_pa_ff <= {sync_pa_ff[1:0], cmp_a_in.pos_pin};
            sync_pb_ff <= {sync_pb_ff[1:0], cmp_b_in.pos_pin};
            sync_na_ff <= {sync_na_ff[1:0], cmp_a_in.neg_pin};
            sync_nb_ff <= {sync_nb_ff[1:0], cmp_b_in.neg_pin};
            sync_a_ff  <= {sync_a_ff[1:0], vref_a_gt};
            sync_b_ff  <= {sync_b_ff[1:0], vref_b_gt};
            sync_t_ff  <= {sync_t_ff[1:0], t0_pin_clk};
            pa_ff      <= filt(sync_pa_ff, pa_ff);
            pb_ff      <= filt(sync_pb_ff, pb_ff);
            na_ff      <= filt(sync_na_ff, na_ff);
            nb_ff      <= filt(sync_nb_ff, nb_ff);
            raw_a_ff   <= filt(sync_a_ff, raw_a_ff);
            raw_b_ff   <= filt(sync_b_ff, raw_b_ff);
            tpin_ff    <= filt(sync_t_ff, tpin_ff);
        end
    end

    //--------------------------------------------------------------
    // comparison
    //--------------------------------------------------------------
    // select one picks B positive pin, else select two decides
    // select two: A positive pin or B negative pin
    assign b_pos = ctrl_b_ff[`CMPC_BIT_SEL1] ? pb_ff : (ctrl_b_ff[`CMPC_BIT_SEL4] ? pa_ff : nb_ff);
    assign b_neg = nb_ff;

    always_comb begin
        // positive above negative gives 1; digital pins stand in
        // negative select: pin when 1, reference compare when 0
        nxt_a = ctrl_a_ff[`CMPC_BIT_NEG] ? (pa_ff & ~na_ff) : raw_a_ff;
        nxt_b = ctrl_b_ff[`CMPC_BIT_NEG] ? (b_pos & ~b_neg) : raw_b_ff;
        nxt_a = pol(nxt_a, ctrl_a_ff[`CMPC_BIT_POL]);
        nxt_b = pol(nxt_b, ctrl_b_ff[`CMPC_BIT_POL]);
    end

    //--------------------------------------------------------------
    // start-up hold
    //--------------------------------------------------------------
    // results wait until the filters hold real pin levels, no false change
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            warm_ff <= 3'h0;
        end else if (warm_ff != `CMPC_WARM_CYCLES) begin
            warm_ff <= warm_ff + 3'h1;
        end
    end

    //--------------------------------------------------------------
    // results and outputs
    //--------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            res_a_ff     <= 1'b1;
            res_b_ff     <= 1'b1;
            res_a_old_ff <= 1'b1;
            res_b_old_ff <= 1'b1;
            out_a_ff     <= 1'b1;
            out_b_ff     <= 1'b1;
            tclk_ff      <= 1'b0;
        end else begin
            if (warm_ff == `CMPC_WARM_CYCLES && ctrl_a_ff[`CMPC_BIT_ENABLE]) begin
                res_a_ff <= nxt_a;
            end
            if (TWO_CMP && warm_ff == `CMPC_WARM_CYCLES && ctrl_b_ff[`CMPC_BIT_ENABLE]) begin
                res_b_ff <= nxt_b;
            end
            res_a_old_ff <= res_a_ff;
            res_b_old_ff <= res_b_ff;
            out_a_ff     <= res_a_ff;
            out_b_ff     <= res_b_ff;
            // comparator output clocks the timer when enabled and select is 0
            if (ctrl_a_ff[`CMPC_BIT_ENABLE] && !ctrl_a_ff[`CMPC_BIT_SEL4]) begin
                tclk_ff <= res_a_ff;
            end else begin
                tclk_ff <= timer_clock_source_option ? tpin_ff : 1'b0;
            end
        end
    end

    // pin drive, wake and timer override assert only while comparator is on
    // pin drive bit low drives the result; oe low means driving
    assign cmp_a_side.result   = res_a_ff;
    assign cmp_a_side.pin_out  = out_a_ff;
    assign cmp_a_side.pin_oe_n = ~(ctrl_a_ff[`CMPC_BIT_ENABLE] & ~ctrl_a_ff[`CMPC_BIT_DRIVE_N]);
    assign cmp_a_side.wake_en  = ctrl_a_ff[`CMPC_BIT_ENABLE] & ~ctrl_a_ff[`CMPC_BIT_WAKE_N];
    assign cmp_b_side.result   = res_b_ff;
    assign cmp_b_side.pin_out  = out_b_ff;
    assign cmp_b_side.pin_oe_n = ~(TWO_CMP & ctrl_b_ff[`CMPC_BIT_ENABLE] & ~ctrl_b_ff[`CMPC_BIT_DRIVE_N]);
    assign cmp_b_side.wake_en  = TWO_CMP & ctrl_b_ff[`CMPC_BIT_ENABLE] & ~ctrl_b_ff[`CMPC_BIT_WAKE_N];
    assign cmp_a_enable       = ctrl_a_ff[`CMPC_BIT_ENABLE];
    assign cmp_b_enable       = TWO_CMP & ctrl_b_ff[`CMPC_BIT_ENABLE];
    // voltage reference only on the two-comparator variant
    assign vref_enable        = TWO_CMP & ~(ctrl_b_ff[`CMPC_BIT_NEG] & ctrl_a_ff[`CMPC_BIT_NEG]);
    assign timer_zero_clk     = tclk_ff;
    assign timer_pin_override = ctrl_a_ff[`CMPC_BIT_ENABLE] & ~ctrl_a_ff[`CMPC_BIT_SEL4];
    assign chg                = {res_b_ff ^ res_b_old_ff, res_a_ff ^ res_a_old_ff};
    // output change wakes the device only when wake bit is 0
    assign wake_req           = (chg[0] & cmp_a_side.wake_en) | (chg[1] & cmp_b_side.wake_en);
    assign irq                = |(irq_stat_ff & irq_mask_ff);

    //--------------------------------------------------------------
    // axi4-lite write
    //--------------------------------------------------------------
    assign s_axi_awready = ~aw_got_ff & ~bvalid_ff;
    assign s_axi_wready  = ~w_got_ff & ~bvalid_ff;
    assign s_axi_bvalid  = bvalid_ff;
    assign s_axi_bresp   = bresp_ff;
    assign wr_go         = aw_got_ff & w_got_ff & ~bvalid_ff;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_ff  <= 1'b0;
            w_got_ff   <= 1'b0;
            aw_addr_ff <= 32'h0000_0000;
            wdata_ff   <= 8'h00;
            wr_strb_ff <= 1'b0;
            bvalid_ff  <= 1'b0;
            bresp_ff   <= `CMPC_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got_ff  <= 1'b1;
                aw_addr_ff <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got_ff   <= 1'b1;
                wdata_ff   <= s_axi_wdata[7:0];
                wr_strb_ff <= s_axi_wstrb[0];
            end
            if (wr_go) begin
                aw_got_ff <= 1'b0;
                w_got_ff  <= 1'b0;
                bvalid_ff <= 1'b1;
                case ({aw_addr_ff[31:2], 2'h0})
                    `CMPC_OFF_CTRL_A, `CMPC_OFF_IRQ_STAT, `CMPC_OFF_IRQ_MASK: bresp_ff <= `CMPC_RESP_OKAY;
                    `CMPC_OFF_CTRL_B: bresp_ff <= TWO_CMP ? `CMPC_RESP_OKAY : `CMPC_RESP_SLVERR;
                    default: bresp_ff <= `CMPC_RESP_SLVERR;
                endcase
            end else if (bvalid_ff && s_axi_bready) begin
                bvalid_ff <= 1'b0;
            end
        end
    end

    //--------------------------------------------------------------
    // control registers
    //--------------------------------------------------------------
    // control A, bit 7 read-only, all bits one after reset
    // control B has the same layout as control A
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_a_ff <= `CMPC_CTRL_RESET;
            ctrl_b_ff <= `CMPC_CTRL_RESET;
        end else if (wr_go && wr_strb_ff) begin
            if ({aw_addr_ff[31:2], 2'h0} == `CMPC_OFF_CTRL_A) begin
                ctrl_a_ff <= {1'b1, wdata_ff[6:0]};
            end
            if (TWO_CMP && {aw_addr_ff[31:2], 2'h0} == `CMPC_OFF_CTRL_B) begin
                ctrl_b_ff <= {1'b1, wdata_ff[6:0]};
            end
        end
    end

    //--------------------------------------------------------------
    // interrupt status and mask
    //--------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_stat_ff <= `CMPC_IRQ_RESET;
            irq_mask_ff <= `CMPC_IRQ_RESET;
        end else begin
            // set wins over write-one-to-clear
            if (wr_go && wr_strb_ff && {aw_addr_ff[31:2], 2'h0} == `CMPC_OFF_IRQ_STAT) begin
                irq_stat_ff <= (irq_stat_ff & ~wdata_ff[1:0]) | chg;
            end else begin
                irq_stat_ff <= irq_stat_ff | chg;
            end
            if (wr_go && wr_strb_ff && {aw_addr_ff[31:2], 2'h0} == `CMPC_OFF_IRQ_MASK) begin
                irq_mask_ff <= wdata_ff[1:0];
            end
        end
    end

    //--------------------------------------------------------------
    // axi4-lite read
    //--------------------------------------------------------------
    assign s_axi_arready = (rd_state_ff == cmpc_pkg::CMPC_RD_IDLE);
    assign s_axi_rvalid  = (rd_state_ff == cmpc_pkg::CMPC_RD_RESP);
    assign s_axi_rdata   = rdata_ff;
    assign s_axi_rresp   = rresp_ff;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rd_state_ff <= cmpc_pkg::CMPC_RD_IDLE;
            rdata_ff    <= 32'h0000_0000;
            rresp_ff    <= `CMPC_RESP_OKAY;
        end else begin
            case (rd_state_ff)
                cmpc_pkg::CMPC_RD_IDLE: begin
                    if (s_axi_arvalid) begin
                        rd_state_ff <= cmpc_pkg::CMPC_RD_RESP;
                        rresp_ff    <= `CMPC_RESP_OKAY;
                        case ({s_axi_araddr[31:2], 2'h0})
                            `CMPC_OFF_CTRL_A: rdata_ff <= {24'h00_0000, res_a_ff, ctrl_a_ff[6:0]};
                            `CMPC_OFF_CTRL_B: begin
                                rdata_ff <= TWO_CMP ? {24'h00_0000, res_b_ff, ctrl_b_ff[6:0]} : 32'h0000_0000;
                                rresp_ff <= TWO_CMP ? `CMPC_RESP_OKAY : `CMPC_RESP_SLVERR;
                            end
                            `CMPC_OFF_IRQ_STAT: rdata_ff <= {30'h0000_0000, irq_stat_ff};
                            `CMPC_OFF_IRQ_MASK: rdata_ff <= {30'h0000_0000, irq_mask_ff};
                            default: begin
                                rdata_ff <= 32'h0000_0000;
                                rresp_ff <= `CMPC_RESP_SLVERR;
                            end
                        endcase
                    end
                end
                cmpc_pkg::CMPC_RD_RESP: begin
                    if (s_axi_rready) begin
                        rd_state_ff <= cmpc_pkg::CMPC_RD_IDLE;
                    end
                end
                default: rd_state_ff <= cmpc_pkg::CMPC_RD_IDLE;
            endcase
        end
    end
endmodule : cmpc_regs

// File: tb/cmpc_regs_chk.sv
// assertion checker of the comparator control register bank
`timescale 1ns/1ps
module cmpc_regs_chk #(
    parameter bit TWO_CMP = 1'b1
) (
    input wire logic                    aclk,
    input wire logic                    aresetn,
    input wire logic                    s_axi_awvalid,
    input wire logic                    s_axi_awready,
    input wire logic                    s_axi_wvalid,
    input wire logic                    s_axi_wready,
    input wire logic                    s_axi_bvalid,
    input wire logic                    s_axi_arvalid,
    input wire logic                    s_axi_arready,
    input wire logic                    s_axi_rvalid,
    input wire cmpc_pkg::cmpc_side_type cmp_a_side,
    input wire cmpc_pkg::cmpc_side_type cmp_b_side,
    input wire logic                    cmp_a_enable,
    input wire logic                    cmp_b_enable,
    input wire logic                    vref_enable,
    input wire logic                    timer_zero_clk,
    input wire logic                    timer_pin_override,
    input wire logic                    timer_clock_source_option,
    input wire logic                    wake_req
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_pin_a; !cmp_a_side.pin_oe_n |-> cmp_a_enable && cmp_a_side.pin_out == $past(cmp_a_side.result);
    endproperty
    a_pin_a: assert property (p_pin_a) else $error("pin a driven wrongly");
    property p_pin_b; !cmp_b_side.pin_oe_n |-> cmp_b_enable && cmp_b_side.pin_out == $past(cmp_b_side.result);
    endproperty
    a_pin_b: assert property (p_pin_b) else $error("pin b driven wrongly");
    property p_wake_a; cmp_a_side.wake_en |-> cmp_a_enable; endproperty
    a_wake_a: assert property (p_wake_a) else $error("wake a while off");
    property p_wake_req; wake_req |-> cmp_a_side.wake_en || cmp_b_side.wake_en
        || $past(cmp_a_side.wake_en) || $past(cmp_b_side.wake_en); endproperty
    a_wake_req: assert property (p_wake_req) else $error("wake without enable");
    property p_tmr_own; timer_pin_override |-> cmp_a_enable; endproperty
    a_tmr_own: assert property (p_tmr_own) else $error("timer owned while off");
    property p_tmr_idle; (!timer_pin_override && !timer_clock_source_option) [*2] |-> !timer_zero_clk; endproperty
    a_tmr_idle: assert property (p_tmr_idle) else $error("timer clock not idle");
    property p_vref; vref_enable |-> TWO_CMP; endproperty
    a_vref: assert property (p_vref) else $error("reference on small variant");
    property p_wresp; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid;
    endproperty
    a_wresp: assert property (p_wresp) else $error("late write response");
    property p_rresp; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
    a_rresp: assert property (p_rresp) else $error("late read response");
endmodule : cmpc_regs_chk

// File: tb/testbench.sv
// self-checking bench of the comparator control register bank
`timescale 1ns/1ps
`include "cmpc_defs.svh"
module testbench;
    logic                      aclk, aresetn, irq, wake_req, timer_pin_override, timer_zero_clk;
    logic [31:0]               s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
    logic [3:0]                s_axi_wstrb;
    logic [1:0]                s_axi_bresp, s_axi_rresp;
    logic                      s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic                      s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic                      vref_a_gt, vref_b_gt, timer_clock_source_option, t0_pin_clk;
    logic                      cmp_a_enable, cmp_b_enable, vref_enable;
    cmpc_pkg::cmpc_analog_type cmp_a_in, cmp_b_in;
    cmpc_pkg::cmpc_side_type   cmp_a_side, cmp_b_side;
    int                        n_fail = 0;
    int                        tests_run = 0;

    cmpc_regs #(.TWO_CMP(1'b1)) dut_u (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .cmp_a_in, .cmp_b_in, .vref_a_gt, .vref_b_gt, .timer_clock_source_option, .t0_pin_clk,
        .cmp_a_side, .cmp_b_side, .cmp_a_enable, .cmp_b_enable, .vref_enable, .timer_zero_clk,
        .timer_pin_override, .wake_req, .irq
    );

    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end

    task automatic summarize;
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : summarize

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic chkb(input logic got, input logic exp);
        chk({31'h0, got}, {31'h0, exp});
    endtask : chkb

    task automatic cyc(input int n);
        repeat (n) @(posedge aclk);
    endtask : cyc

    task automatic timeout;
        n_fail++;
        $display("BAD %0t bus wait ran out", $time);
        summarize();
    endtask : timeout

    // ----------------------------------------
    // bus master
    // ----------------------------------------
    task automatic wr(input logic [31:0] a, d, input logic [3:0] s, input logic [1:0] er);
        int i;
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_wstrb   <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        for (i = 0; i < 40; i++) begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        s_axi_bready <= 1'b0;
        if (i == 40) timeout();
        chk({30'h0, s_axi_bresp}, {30'h0, er});
        // one idle edge before the next transfer
        @(posedge aclk);
    endtask : wr

    task automatic rd(input logic [31:0] a, exp, input logic [1:0] er);
        int i;
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        for (i = 0; i < 40; i++) begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        s_axi_rready <= 1'b0;
        if (i == 40) timeout();
        chk(s_axi_rdata, exp);
        chk({30'h0, s_axi_rresp}, {30'h0, er});
        @(posedge aclk);
    endtask : rd

    task automatic wset(input logic [31:0] a, d);
        wr(a, d, 4'hf, `CMPC_RESP_OKAY);
        cyc(10);
    endtask : wset

    task automatic wake_seen(input logic exp);
        logic seen;
        seen = 1'b0;
        repeat (20) begin
            @(posedge aclk);
            seen = seen | wake_req;
        end
        chkb(seen, exp);
    endtask : wake_seen

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset;
        rd(`CMPC_OFF_CTRL_A, 32'hff, `CMPC_RESP_OKAY);
        rd(`CMPC_OFF_CTRL_B, 32'hff, `CMPC_RESP_OKAY);
        rd(`CMPC_OFF_IRQ_STAT, 32'h0, `CMPC_RESP_OKAY);
        rd(`CMPC_OFF_IRQ_MASK, 32'h0, `CMPC_RESP_OKAY);
        chkb(cmp_a_side.pin_oe_n, 1'b1);
        chkb(irq, 1'b0);
        wset(`CMPC_OFF_CTRL_A, 32'h0);
        rd(`CMPC_OFF_CTRL_A, 32'h80, `CMPC_RESP_OKAY);
        chkb(cmp_a_enable, 1'b0);
        $display("t_reset done");
    endtask : t_reset

    task automatic t_a;
        wset(`CMPC_OFF_CTRL_A, 32'h2e);
        rd(`CMPC_OFF_CTRL_A, 32'hae, `CMPC_RESP_OKAY);
        chk({cmp_a_side.pin_oe_n, cmp_a_side.pin_out, cmp_a_side.wake_en, cmp_a_side.result}, 32'h7);
        chk({timer_pin_override, timer_zero_clk, cmp_a_enable}, 32'h7);
        cmp_a_in.pos_pin <= 1'b0;
        wake_seen(1'b1);
        rd(`CMPC_OFF_CTRL_A, 32'h2e, `CMPC_RESP_OKAY);
        chkb(timer_zero_clk, 1'b0);
        wset(`CMPC_OFF_CTRL_A, 32'h0e);
        rd(`CMPC_OFF_CTRL_A, 32'h8e, `CMPC_RESP_OKAY);
        wset(`CMPC_OFF_CTRL_A, 32'h4f);
        chk({cmp_a_side.pin_oe_n, cmp_a_side.wake_en}, 32'h2);
        cmp_a_in.pos_pin <= 1'b1;
        wake_seen(1'b0);
        wset(`CMPC_OFF_CTRL_A, 32'h2a);
        vref_a_gt <= 1'b1;
        cyc(10);
        rd(`CMPC_OFF_CTRL_A, 32'haa, `CMPC_RESP_OKAY);
        chkb(vref_enable, 1'b1);
        vref_a_gt <= 1'b0;
        cyc(10);
        rd(`CMPC_OFF_CTRL_A, 32'h2a, `CMPC_RESP_OKAY);
        $display("t_a done");
    endtask : t_a

    task automatic t_tmr;
        wset(`CMPC_OFF_CTRL_A, 32'h3e);
        chkb(timer_pin_override, 1'b0);
        timer_clock_source_option <= 1'b1;
        t0_pin_clk <= 1'b1;
        cyc(8);
        chkb(timer_zero_clk, 1'b1);
        t0_pin_clk <= 1'b0;
        cyc(8);
        chkb(timer_zero_clk, 1'b0);
        wset(`CMPC_OFF_CTRL_A, 32'h26);
        t0_pin_clk <= 1'b1;
        cyc(8);
        chk({timer_pin_override, cmp_a_side.pin_oe_n, timer_zero_clk}, 32'h3);
        timer_clock_source_option <= 1'b0;
        cyc(3);
        chkb(timer_zero_clk, 1'b0);
        $display("t_tmr done");
    endtask : t_tmr

    task automatic t_b;
        cmp_a_in.pos_pin <= 1'b0;
        wset(`CMPC_OFF_CTRL_B, 32'h3f);
        rd(`CMPC_OFF_CTRL_B, 32'hbf, `CMPC_RESP_OKAY);
        chk({cmp_b_side.pin_oe_n, cmp_b_enable}, 32'h1);
        wset(`CMPC_OFF_CTRL_B, 32'h3d);
        rd(`CMPC_OFF_CTRL_B, 32'h3d, `CMPC_RESP_OKAY);
        cmp_a_in.pos_pin <= 1'b1;
        cyc(10);
        rd(`CMPC_OFF_CTRL_B, 32'hbd, `CMPC_RESP_OKAY);
        chk({cmp_b_side.result, cmp_b_side.pin_out, cmp_b_side.wake_en}, 32'h6);
        wset(`CMPC_OFF_CTRL_B, 32'h2d);
        rd(`CMPC_OFF_CTRL_B, 32'h2d, `CMPC_RESP_OKAY);
        $display("t_b done");
    endtask : t_b

    task automatic t_irq;
        wset(`CMPC_OFF_CTRL_A, 32'h2f);
        wset(`CMPC_OFF_IRQ_STAT, 32'h3);
        wset(`CMPC_OFF_IRQ_MASK, 32'h1);
        chkb(irq, 1'b0);
        cmp_a_in.pos_pin <= 1'b0;
        cyc(10);
        chkb(irq, 1'b1);
        rd(`CMPC_OFF_IRQ_STAT, 32'h1, `CMPC_RESP_OKAY);
        wset(`CMPC_OFF_IRQ_MASK, 32'h2);
        chkb(irq, 1'b0);
        wset(`CMPC_OFF_IRQ_MASK, 32'h3);
        chkb(irq, 1'b1);
        wset(`CMPC_OFF_IRQ_STAT, 32'h1);
        chkb(irq, 1'b0);
        rd(`CMPC_OFF_IRQ_STAT, 32'h0, `CMPC_RESP_OKAY);
        rd(32'h10, 32'h0, `CMPC_RESP_SLVERR);
        wr(32'h10, 32'hff, 4'hf, `CMPC_RESP_SLVERR);
        wr(`CMPC_OFF_CTRL_A, 32'h0, 4'h0, `CMPC_RESP_OKAY);
        rd(`CMPC_OFF_CTRL_A, 32'h2f, `CMPC_RESP_OKAY);
        $display("t_irq done");
    endtask : t_irq

    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {vref_a_gt, vref_b_gt, timer_clock_source_option, t0_pin_clk} = '0;
        {s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_wstrb} = '0;
        cmp_a_in = 2'h2;
        cmp_b_in = 2'h2;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_reset();
        t_a();
        t_tmr();
        t_b();
        t_irq();
        summarize();
    end
endmodule : testbench

bind cmpc_regs cmpc_regs_chk #(.TWO_CMP(TWO_CMP)) chk_u (
    .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .cmp_a_side, .cmp_b_side, .cmp_a_enable,
    .cmp_b_enable, .vref_enable, .timer_zero_clk, .timer_pin_override, .timer_clock_source_option,
    .wake_req
);
